// file: core/tef_consts.svh
`ifndef TEF_CONSTS_SVH
`define TEF_CONSTS_SVH
// Register offsets
`define TEF_OFF_ENABLE 12'h00C
`define TEF_OFF_STATUS 12'h010
// Control word of own choosing
`define TEF_OFF_CTRL 12'h014
// Reset values
`define TEF_RST_ENABLE 16'h0000
`define TEF_RST_STATUS 16'h0000
`define TEF_RST_CTRL 16'h0000
// Enable register fields
`define TEF_EN_UPD_IRQ 0
`define TEF_EN_CH_IRQ 1
`define TEF_EN_TRIG_IRQ 6
`define TEF_EN_UPD_DMA 8
`define TEF_EN_CH_DMA 9
`define TEF_EN_TRIG_DMA 14
// Status register fields
`define TEF_ST_UPD 0
`define TEF_ST_CH 1
`define TEF_ST_TRIG 6
`define TEF_ST_OVR 9
// Writable masks
`define TEF_ENABLE_MASK 16'h5F5F
`define TEF_STATUS_MASK 16'h1E5F
// Control word fields
`define TEF_CT_BLOCK 0
`define TEF_CT_SRC 1
`define TEF_CT_SLAVE 4
`define TEF_CT_INPUT 8
// Gated slave mode code
`define TEF_SLAVE_GATED 3'h5
`endif

// file: core/tef_pkg.sv
package tef_pkg;
  typedef enum logic [1:0] {
    TEF_CNT_UP,
    TEF_CNT_DOWN,
    TEF_CNT_CENTER
  } tef_cnt_mode_t;

  // Event strobes from the timer kernel, one cycle each
  typedef struct packed {
    logic overflow;
    logic underflow;
    logic sw_update;
    logic slave_reinit;
    logic trig_edge;
    logic [3:0] cmp_match;
    logic [3:0] center_hit;
    logic [3:0] cmp_above_reload;
    logic [3:0] capture;
    logic sw_trigger;
    logic [3:0] sw_chan;
  } tef_events_t;

  typedef struct packed {
    logic upd;
    logic trig;
    logic [3:0] ch;
  } tef_dma_t;
endpackage : tef_pkg

// file: core/tef_flags.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`include "tef_consts.svh"

module tef_flags
  import tef_pkg::*;
#(
  parameter int NCH = 4
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Kernel side
  input wire tef_events_t ev,
  input wire tef_cnt_mode_t cnt_mode,
  input wire logic trig_level,
  input wire logic [NCH-1:0] capdata_rd,
  // Requests
  output logic irq,
  output tef_dma_t dma_req
);

  // ******************************
  // Bus decode
  // ******************************
  logic acc, wr_en, wr_st, wr_ct, hit;
  assign acc = psel && penable;
  assign hit = (paddr == `TEF_OFF_ENABLE) || (paddr == `TEF_OFF_STATUS) ||
               (paddr == `TEF_OFF_CTRL);
  assign pready = 1'b1;
  assign pslverr = acc && !hit;
  assign wr_en = acc && pwrite && (paddr == `TEF_OFF_ENABLE);
  assign wr_st = acc && pwrite && (paddr == `TEF_OFF_STATUS);
  assign wr_ct = acc && pwrite && (paddr == `TEF_OFF_CTRL);

  logic [15:0] enable_q, status_q, ctrl_q;
  logic [15:0] status_d;
  logic [15:0] enable_d;
  // Next value feeds irq so it never lags a fresh enable by a cycle
  assign enable_d = wr_en ? (pwdata[15:0] & `TEF_ENABLE_MASK) : enable_q;

  // ******************************
  // Registers
  // ******************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= `TEF_RST_ENABLE;
    end else begin
      enable_q <= enable_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `TEF_RST_CTRL;
    end else if (wr_ct) begin
      ctrl_q <= pwdata[15:0];
    end
  end

  logic upd_block, upd_src, gated;
  logic [NCH-1:0] ch_input;
  assign upd_block = ctrl_q[`TEF_CT_BLOCK];
  assign upd_src = ctrl_q[`TEF_CT_SRC];
  assign gated = (ctrl_q[`TEF_CT_SLAVE +: 3] == `TEF_SLAVE_GATED);
  assign ch_input = ctrl_q[`TEF_CT_INPUT +: NCH];

  // ******************************
  // Event sources
  // ******************************
  logic trig_q, trig_set, upd_set;
  logic [NCH-1:0] ch_set, ovr_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= trig_level;
    end
  end

  // Gated mode watches the level, so both edges count
  assign trig_set = ev.sw_trigger ||
                    (gated ? (trig_level != trig_q)
                           : ev.trig_edge);

  assign upd_set = !upd_block && (ev.overflow || ev.underflow ||
                   (!upd_src && (ev.sw_update ||
                                 ev.slave_reinit)));

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic cmp_hit;
      always_comb begin
        // Above reload the wrap replaces the match, center mode too
        if (ev.cmp_above_reload[g]) begin
          cmp_hit = (cnt_mode == TEF_CNT_DOWN) ? ev.underflow
                                               : ev.overflow;
        end else if (cnt_mode == TEF_CNT_CENTER) begin
          cmp_hit = ev.center_hit[g];
        end else begin
          cmp_hit = ev.cmp_match[g];
        end
      end
      assign ch_set[g] = ch_input[g] ? (ev.capture[g] || ev.sw_chan[g])
                                     : (cmp_hit || ev.sw_chan[g]);
      assign ovr_set[g] = ch_input[g] && ch_set[g] &&
                          status_q[`TEF_ST_CH + g];

      // ******************************
      // Channel checks
      // ******************************
      a_ch_irq: assert property (@(posedge pclk)
        disable iff (!presetn)
        status_q[`TEF_ST_CH + g] && enable_q[`TEF_EN_CH_IRQ + g] |-> irq)
        else $error("channel irq missing");
      a_ch_dma_gate: assert property (@(posedge pclk)
        disable iff (!presetn)
        !enable_q[`TEF_EN_CH_DMA + g] |=> !dma_req.ch[g])
        else $error("channel dma without enable");
      a_ch_capture: assert property (@(posedge pclk)
        disable iff (!presetn)
        ch_input[g] && ev.capture[g] |=> status_q[`TEF_ST_CH + g])
        else $error("capture flag not set");
      a_ch_match: assert property (@(posedge pclk)
        disable iff (!presetn)
        !ch_input[g] && cnt_mode != TEF_CNT_CENTER &&
        !ev.cmp_above_reload[g] && ev.cmp_match[g]
        |=> status_q[`TEF_ST_CH + g])
        else $error("compare flag not set");
      a_ch_center: assert property (@(posedge pclk)
        disable iff (!presetn)
        !ch_input[g] && cnt_mode == TEF_CNT_CENTER &&
        !ev.cmp_above_reload[g] && ev.center_hit[g]
        |=> status_q[`TEF_ST_CH + g])
        else $error("center compare flag not set");
      a_ch_reload: assert property (@(posedge pclk)
        disable iff (!presetn)
        !ch_input[g] && ev.cmp_above_reload[g] &&
        (cnt_mode == TEF_CNT_DOWN ? ev.underflow : ev.overflow)
        |=> status_q[`TEF_ST_CH + g])
        else $error("reload wrap flag not set");
      a_ch_sw: assert property (@(posedge pclk)
        disable iff (!presetn)
        ev.sw_chan[g] |=> status_q[`TEF_ST_CH + g])
        else $error("software channel event lost");
      a_ovr_chan: assert property (@(posedge pclk)
        disable iff (!presetn)
        ch_input[g] && ev.capture[g] && status_q[`TEF_ST_CH + g]
        |=> status_q[`TEF_ST_OVR + g])
        else $error("overrun not set");
      a_ovr_output: assert property (@(posedge pclk)
        disable iff (!presetn)
        !ch_input[g] && !status_q[`TEF_ST_OVR + g]
        |=> !status_q[`TEF_ST_OVR + g])
        else $error("overrun set in output mode");
    end
  endgenerate

  // ******************************
  // Status flags
  // ******************************
  always_comb begin
    status_d = status_q;
    if (wr_st) begin
      status_d = status_q & (pwdata[15:0] | ~`TEF_STATUS_MASK);
    end
    for (int i = 0; i < NCH; i++) begin
      if (ch_input[i] && capdata_rd[i]) begin
        status_d[`TEF_ST_CH + i] = 1'b0;
      end
    end
    // Hardware set applied last so it wins over any clear
    if (upd_set) begin
      status_d[`TEF_ST_UPD] = 1'b1;
    end
    if (trig_set) begin
      status_d[`TEF_ST_TRIG] = 1'b1;
    end
    for (int i = 0; i < NCH; i++) begin
      if (ch_set[i]) begin
        status_d[`TEF_ST_CH + i] = 1'b1;
      end
      if (ovr_set[i]) begin
        status_d[`TEF_ST_OVR + i] = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= `TEF_RST_STATUS;
    end else begin
      status_q <= status_d;
    end
  end

  // ******************************
  // Read data
  // ******************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == `TEF_OFF_ENABLE) begin
        prdata <= {16'h0000, enable_q};
      end else if (paddr == `TEF_OFF_STATUS) begin
        prdata <= {16'h0000, status_q};
      end else if (paddr == `TEF_OFF_CTRL) begin
        prdata <= {16'h0000, ctrl_q};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // ******************************
  // Requests
  // ******************************
  // Level interrupt, held until software clears the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_d[6:0] & enable_d[6:0] & 7'h5F);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_req <= '0;
    end else begin
      dma_req.upd <= upd_set && enable_q[`TEF_EN_UPD_DMA];
      dma_req.trig <= trig_set && enable_q[`TEF_EN_TRIG_DMA];
      dma_req.ch <= ch_set & enable_q[`TEF_EN_CH_DMA +: NCH];
    end
  end

  // ******************************
  // Assertions
  // ******************************
  a_upd_dma_gate: assert property (@(posedge pclk) disable iff (!presetn)
    upd_set && !enable_q[8] |=> !dma_req.upd)
    else $error("update dma without enable");
  a_trig_dma: assert property (@(posedge pclk) disable iff (!presetn)
    trig_set && enable_q[14] |=> dma_req.trig)
    else $error("trigger dma missing");
  a_ch_dma: assert property (@(posedge pclk) disable iff (!presetn)
    ch_set[0] && enable_q[9] |=> dma_req.ch[0])
    else $error("channel dma missing");
  a_irq_upd: assert property (@(posedge pclk) disable iff (!presetn)
    status_q[0] && enable_q[0] |-> irq)
    else $error("update irq missing");
  a_irq_trig: assert property (@(posedge pclk) disable iff (!presetn)
    status_q[6] && enable_q[6] |-> irq)
    else $error("trigger irq missing");
  a_irq_none: assert property (@(posedge pclk) disable iff (!presetn)
    (status_q[6:0] & enable_q[6:0]) == 7'h00 |-> !irq)
    else $error("spurious irq");
  a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    wr_st && pwdata[0] == 1'b0 && upd_set |=> status_q[0])
    else $error("set lost to clear");
  a_ovr_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    status_q[9] && !wr_st |=> status_q[9])
    else $error("overrun flag dropped");
  a_ovr_cause: assert property (@(posedge pclk) disable iff (!presetn)
    ch_input[0] && ev.capture[0] && status_q[1] |=> status_q[9])
    else $error("overrun not set");
  a_upd_blocked: assert property (@(posedge pclk) disable iff (!presetn)
    upd_block && !status_q[0] |=> !status_q[0])
    else $error("update set while blocked");
  a_gated_edge: assert property (@(posedge pclk) disable iff (!presetn)
    gated && $changed(trig_level) |=> status_q[6])
    else $error("gated edge missed");
  a_cap_rd_clr: assert property (@(posedge pclk) disable iff (!presetn)
    ch_input[0] && capdata_rd[0] && !ch_set[0] |=> !status_q[1])
    else $error("capture read did not clear");
  a_enable_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && !upd_set && !trig_set && ch_set == '0 && !wr_st
    && capdata_rd == '0 |=> status_q == $past(status_q))
    else $error("enable write changed flags");
  a_trig_edge: assert property (@(posedge pclk)
    disable iff (!presetn)
    !gated && ev.trig_edge |=> status_q[`TEF_ST_TRIG])
    else $error("trigger edge missed");
  a_trig_sw: assert property (@(posedge pclk)
    disable iff (!presetn)
    ev.sw_trigger |=> status_q[`TEF_ST_TRIG])
    else $error("software trigger lost");
  a_gated_level: assert property (@(posedge pclk)
    disable iff (!presetn)
    gated && !ev.sw_trigger && $stable(trig_level) &&
    !status_q[`TEF_ST_TRIG] |=> !status_q[`TEF_ST_TRIG])
    else $error("gated flag without edge");
  a_upd_sets: assert property (@(posedge pclk)
    disable iff (!presetn)
    !upd_block && (ev.overflow || ev.underflow) |=> status_q[`TEF_ST_UPD])
    else $error("update flag not set");
  a_upd_source: assert property (@(posedge pclk)
    disable iff (!presetn)
    upd_src && !ev.overflow && !ev.underflow &&
    !status_q[`TEF_ST_UPD] |=> !status_q[`TEF_ST_UPD])
    else $error("update set from blocked source");
  a_upd_forced: assert property (@(posedge pclk)
    disable iff (!presetn)
    !upd_block && !upd_src && (ev.sw_update || ev.slave_reinit)
    |=> status_q[`TEF_ST_UPD])
    else $error("forced update flag not set");
  a_upd_block_dma: assert property (@(posedge pclk)
    disable iff (!presetn)
    upd_block |=> !dma_req.upd)
    else $error("update dma while blocked");
  a_trig_dma_gate: assert property (@(posedge pclk)
    disable iff (!presetn)
    !enable_q[`TEF_EN_TRIG_DMA] |=> !dma_req.trig)
    else $error("trigger dma without enable");
  a_upd_dma: assert property (@(posedge pclk)
    disable iff (!presetn)
    upd_set && enable_q[`TEF_EN_UPD_DMA] |=> dma_req.upd)
    else $error("update dma missing");
  a_ovr_clear: assert property (@(posedge pclk)
    disable iff (!presetn)
    wr_st && !pwdata[`TEF_ST_OVR] && !ovr_set[0] |=> !status_q[`TEF_ST_OVR])
    else $error("overrun not cleared");
  a_read_enable: assert property (@(posedge pclk)
    disable iff (!presetn)
    psel && !penable && !pwrite && paddr == `TEF_OFF_ENABLE
    |=> prdata == {16'h0000, $past(enable_q)})
    else $error("enable readback wrong");
  a_reserved_zero: assert property (@(posedge pclk)
    disable iff (!presetn)
    (status_q & ~`TEF_STATUS_MASK) == 16'h0000 &&
    (enable_q & ~`TEF_ENABLE_MASK) == 16'h0000)
    else $error("reserved bit set");

  c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
  c_ovr: cover property (@(posedge pclk) disable iff (!presetn)
    ovr_set[0]);
  c_clash: cover property (@(posedge pclk) disable iff (!presetn)
    wr_st && upd_set);
  c_dma: cover property (@(posedge pclk) disable iff (!presetn)
    dma_req.trig);
  c_center: cover property (@(posedge pclk) disable iff (!presetn)
    cnt_mode == TEF_CNT_CENTER && ch_set != '0);

endmodule : tef_flags

// file: tb/tef_sink.sv
`timescale 1ns/10ps
// ****************
// Request sink
// ****************
module tef_sink
  import tef_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requests
  input wire tef_dma_t dma_req,
  // Pulses taken
  output int dma_cnt
);
  // Every pulse is one transfer, so all lines are summed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_cnt <= 0;
    end else begin
      dma_cnt <= dma_cnt + $countones(dma_req);
    end
  end
endmodule : tef_sink

// file: tb/tef_flags_bench.sv
`timescale 1ns/10ps
`include "tef_consts.svh"
// ****************
// Bench
// ****************
module tef_flags_bench
  import tef_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic trig_level = 1'b0;
  logic [3:0] capdata_rd = 4'h0;
  tef_events_t ev = '0;
  tef_dma_t dma_req;
  tef_cnt_mode_t cmode = TEF_CNT_UP;
  tef_events_t e = '0;
  int fails = 0;
  int cmp_count = 0;
  int dma_cnt;
  int dmax;
  logic er;
  logic [31:0] rd;
  logic [31:0] seed = 32'h00000061;
  logic [15:0] ct [7] = '{16'h0001, 16'h0002, 16'h0001, 16'h0000,
    16'h0002, 16'h0000, 16'h0000};
  int sl [7] = '{0, 6, 6, 6, 7, 7, 9};
  logic xb [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

  always #50 pclk = ~pclk;

  tef_flags DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ev(ev),
    .cnt_mode(cmode), .trig_level(trig_level),
    .capdata_rd(capdata_rd), .irq(irq), .dma_req(dma_req));
  tef_sink SINK (.pclk(pclk), .presetn(presetn), .dma_req(dma_req),
    .dma_cnt(dma_cnt));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // Status bit of an event; its DMA enable sits eight above
  function automatic int fbit(input int k);
    return (k == 0) ? 0 : (k == 1) ? 6 : k - 1;
  endfunction : fbit

  function automatic tef_events_t mk(input int s);
    mk = '0;
    case (s)
      0: mk.overflow = 1'b1;
      1: mk.trig_edge = 1'b1;
      6: mk.sw_update = 1'b1;
      7: mk.slave_reinit = 1'b1;
      8: mk.capture = 4'hF;
      9: mk.underflow = 1'b1;
      default: mk.cmp_match[s-2] = 1'b1;
    endcase
  endfunction : mk

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus

  task pulse(input tef_events_t x);
    @(posedge pclk);
    ev <= x;
    @(posedge pclk);
    ev <= '0;
  endtask : pulse

  task step(input logic [15:0] c, input tef_events_t x, input logic [15:0] f);
    bus(1'b1, `TEF_OFF_CTRL, {16'h0000, c});
    bus(1'b1, `TEF_OFF_STATUS, 32'h00000000);
    dmax = dma_cnt;
    pulse(x);
    bus(1'b0, `TEF_OFF_STATUS, 32'h00000000);
    chk("status", {16'h0000, f}, rd);
  endtask : step

  task print_verdict;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    print_verdict();
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b0, `TEF_OFF_ENABLE, 32'h00000000);
    chk("enable", 32'h00000000, rd);
    bus(1'b0, `TEF_OFF_STATUS, 32'h00000000);
    chk("status", 32'h00000000, rd);
    bus(1'b1, 12'h020, 32'h00000001);
    chk("slverr", 32'h00000001, {31'h0, er});
    repeat (4) begin
      seed = xs(seed);
      bus(1'b1, `TEF_OFF_ENABLE, {16'h0, seed[15:0] & `TEF_ENABLE_MASK});
      bus(1'b0, `TEF_OFF_ENABLE, 32'h00000000);
      chk("enable", {16'h0, seed[15:0] & `TEF_ENABLE_MASK}, rd);
    end
    $display("reset and enable test done");
    for (int i = 0; i < 12; i++) begin
      int k;
      logic on;
      k = i / 2;
      on = (i % 2 == 1);
      bus(1'b1, `TEF_OFF_ENABLE,
        on ? (32'h1 << fbit(k)) | (32'h1 << (fbit(k) + 8)) : 32'h0);
      step(16'h0000, mk(k), 16'h1 << fbit(k));
      chk("irq", {31'h0, on}, {31'h0, irq});
      chk("dma", 32'(dmax) + on, 32'(dma_cnt));
    end
    bus(1'b1, `TEF_OFF_STATUS, {16'h0, `TEF_STATUS_MASK});
    bus(1'b0, `TEF_OFF_STATUS, 32'h00000000);
    chk("status", 32'h00000010, rd);
    $display("event and request test done");
    for (int j = 0; j < 7; j++) begin
      step(ct[j], mk(sl[j]), {15'h0, xb[j]});
    end
    fork
      bus(1'b1, `TEF_OFF_STATUS, 32'h00000000);
      begin
        repeat (2) @(posedge pclk);
        ev <= mk(0);
        @(posedge pclk);
        ev <= '0;
      end
    join
    bus(1'b0, `TEF_OFF_STATUS, 32'h00000000);
    chk("status", 32'h00000001, rd);
    $display("update gating test done");
    step(16'h0F00, mk(8), 16'h001E);
    pulse(mk(8));
    bus(1'b0, `TEF_OFF_STATUS, 32'h00000000);
    chk("status", 32'h00001E1E, rd);
    @(posedge pclk);
    capdata_rd <= 4'hF;
    @(posedge pclk);
    capdata_rd <= 4'h0;
    bus(1'b0, `TEF_OFF_STATUS, 32'h00000000);
    chk("status", 32'h00001E00, rd);
    bus(1'b1, `TEF_OFF_STATUS, 32'h00000000);
    bus(1'b0, `TEF_OFF_STATUS, 32'h00000000);
    chk("status", 32'h00000000, rd);
    $display("capture test done");
    e = '0;
    e.cmp_above_reload = 4'h1;
    e.overflow = 1'b1;
    step(16'h0000, e, 16'h0003);
    cmode <= TEF_CNT_DOWN;
    e.cmp_above_reload = 4'h2;
    step(16'h0000, e, 16'h0001);
    e.overflow = 1'b0;
    e.underflow = 1'b1;
    step(16'h0000, e, 16'h0005);
    cmode <= TEF_CNT_CENTER;
    e = '0;
    e.center_hit = 4'h4;
    e.cmp_match = 4'h8;
    step(16'h0000, e, 16'h0008);
    cmode <= TEF_CNT_UP;
    e = '0;
    e.sw_trigger = 1'b1;
    e.sw_chan = 4'h1;
    step(16'h0150, e, 16'h0042);
    pulse(e);
    bus(1'b0, `TEF_OFF_STATUS, 32'h00000000);
    chk("status", 32'h00000242, rd);
    $display("mode and software event test done");
    step(16'h0050, mk(1), 16'h0000);
    for (int t = 0; t < 2; t++) begin
      @(posedge pclk);
      trig_level <= (t == 0);
      repeat (3) @(posedge pclk);
      bus(1'b0, `TEF_OFF_STATUS, 32'h00000000);
      chk("status", 32'h00000040, rd);
      bus(1'b1, `TEF_OFF_STATUS, 32'h00000000);
    end
    $display("gated trigger test done");
    bus(1'b1, `TEF_OFF_ENABLE, {16'h0000, `TEF_ENABLE_MASK});
    e = '0;
    e.sw_trigger = 1'b1;
    pulse(e);
    @(posedge pclk);
    chk("irq", 32'h00000001, {31'h0, irq});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b0, `TEF_OFF_ENABLE, 32'h00000000);
    chk("enable", 32'h00000000, rd);
    chk("irq", 32'h00000000, {31'h0, irq});
    $display("second reset test done");
    print_verdict();
  end
endmodule : tef_flags_bench
